// ---- inc/tlic_pkg.sv ----
// How it works
// - high requests vector 0008h, low 0018h
// - enabled high request preempts running low routine
// - seventeen registers mapped onto port groups
// - each source has flag, enable, priority
// - priority mode bit7 of reset control, clear
// - bit7 gates high sources, bit6 low sources
// - flag, enable, global enable set: vector immediately
// - compat mode: bit7 all, bit6 also peripherals
// - compat mode always vectors to 0008h
// - accepting clears the admitting global enable
// - low requests held off during high routine
// - push return address, load vector into pc
// - return instruction exits, sets global enable again
// - pin event to vector three-four cycles
// - flags set regardless of any enable
// - edge select one rising, zero falling
package tlic_pkg;
   localparam int PC_W = 21;
   localparam logic [PC_W-1:0] VEC_HIGH = 21'h000008;
   localparam logic [PC_W-1:0] VEC_LOW = 21'h000018;
   localparam int REG_W = 8;
   localparam int PMODE_BIT = 7;
   localparam int GEN_HIGH_BIT = 7;
   localparam int GEN_LOW_BIT = 6;
   localparam logic RST_PMODE = 1'b0;
   localparam logic RST_GEN = 1'b0;
   localparam int N_EXT = 4;
   localparam int N_CHG = 4;
   localparam int SRC_EXT_LO = 0;
   localparam int SRC_CHG = 4;
   localparam int SRC_PERIPH_LO = 5;
   localparam int SYNC_STAGES = 2;
   typedef enum logic [3:0] {
      ST_NONE = 4'h1,
      ST_LOW = 4'h2,
      ST_HIGH = 4'h4,
      ST_NEST = 4'h8
   } tlic_state_t;
endpackage

// ---- inc/tlic_pin_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface tlic_pin_if;
   logic pin;
   logic edge_sel;
   logic any_edge;
   logic evt;
   modport det (input pin, input edge_sel, input any_edge, output evt);
   modport host (output pin, output edge_sel, output any_edge, input evt);
endinterface
`default_nettype wire

// ---- core/tlic_pin_detect.sv ----
`timescale 1ns/1ns
`default_nettype none
module tlic_pin_detect (
   input wire logic i_clk,
   input wire logic i_nrst,
   tlic_pin_if.det pif
);
   import tlic_pkg::*;
   logic [SYNC_STAGES-1:0] sync;
   logic [SYNC_STAGES-1:0] next_sync;
   logic [SYNC_STAGES:0] ready;
   logic [SYNC_STAGES:0] next_ready;
   logic prev;
   logic next_prev;
   logic rise;
   logic fall;

   always_comb begin
      next_sync = {sync[SYNC_STAGES-2:0], pif.pin};
      next_prev = sync[SYNC_STAGES-1];
      next_ready = {ready[SYNC_STAGES-1:0], 1'b1};
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         sync <= '0;
         prev <= 1'b0;
         ready <= '0;
      end else begin
         sync <= next_sync;
         prev <= next_prev;
         ready <= next_ready;
      end
   end

   // only the last sync stage and its delayed copy feed the detector; it stays
   // quiet until the pipe holds real pin samples, so a pin idling high after
   // reset gives no false edge
   assign rise = ready[SYNC_STAGES] & sync[SYNC_STAGES-1] & ~prev;
   assign fall = ready[SYNC_STAGES] & ~sync[SYNC_STAGES-1] & prev;
   assign pif.evt = pif.any_edge ? (rise | fall) : (pif.edge_sel ? rise : fall);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_edge_rise_pulse: assert property (
      ready[0] && $rose(pif.pin) && pif.edge_sel && !pif.any_edge ##1 pif.pin && pif.edge_sel
      |-> ##1 pif.evt)
      else $error("rising pin edge did not raise an event two cycles later");
   a_edge_fall_quiet: assert property (
      !pif.any_edge && !pif.edge_sel && pif.evt |-> !$past(pif.pin, 2) && $past(pif.pin, 3))
      else $error("falling-edge select produced an event without a falling edge");
endmodule
`default_nettype wire

// ---- core/tlic_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module tlic_core #(
   parameter int N_PERIPH = 8,
   localparam int N_SRC = tlic_pkg::SRC_PERIPH_LO + N_PERIPH
) (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic [tlic_pkg::N_EXT-1:0] i_ext_pin,
   input wire logic [tlic_pkg::N_EXT-1:0] i_external_edge_select,
   input wire logic [tlic_pkg::N_CHG-1:0] i_chg_pin,
   input wire logic [N_PERIPH-1:0] i_periph_evt,
   input wire logic [N_SRC-1:0] i_source_enable,
   input wire logic [N_SRC-1:0] i_source_priority,
   input wire logic [N_SRC-1:0] i_flag_clr,
   input wire logic i_reset_control_wr,
   input wire logic [tlic_pkg::REG_W-1:0] i_reset_control_wdata,
   input wire logic i_interrupt_control_wr,
   input wire logic [tlic_pkg::REG_W-1:0] i_interrupt_control_wdata,
   input wire logic i_return_from_interrupt_instr,
   input wire logic [tlic_pkg::PC_W-1:0] i_return_pc,
   output logic [N_SRC-1:0] o_flags,
   output logic o_priority_mode_enable,
   output logic [tlic_pkg::REG_W-1:0] o_interrupt_control,
   output logic o_high_active,
   output logic o_low_active,
   output logic o_vector_load,
   output logic [tlic_pkg::PC_W-1:0] o_vector_addr,
   output logic [tlic_pkg::PC_W-1:0] o_push_addr,
   output logic o_wake
);
   import tlic_pkg::*;

   logic [N_EXT-1:0] ext_evt;
   logic [N_CHG-1:0] chg_evt;
   logic [N_SRC-1:0] src_evt;
   logic [N_SRC-1:0] flags;
   logic [N_SRC-1:0] next_flags;
   logic [N_SRC-1:0] periph_mask;
   logic [N_SRC-1:0] armed;
   logic pmode;
   logic next_pmode;
   logic gen_high;
   logic next_gen_high;
   logic gen_low;
   logic next_gen_low;
   tlic_state_t state;
   tlic_state_t next_state;
   logic hi_busy;
   logic hi_cand;
   logic lo_cand;
   logic take_high;
   logic take_low;
   logic vec_load;
   logic next_vec_load;
   logic [PC_W-1:0] vec_addr;
   logic [PC_W-1:0] next_vec_addr;
   logic [PC_W-1:0] push_addr;
   logic [PC_W-1:0] next_push_addr;

   genvar g;
   generate
      for (g = 0; g < N_EXT; g++) begin : g_ext
         tlic_pin_if pif();
         assign pif.pin = i_ext_pin[g];
         assign pif.edge_sel = i_external_edge_select[g];
         assign pif.any_edge = 1'b0;
         assign ext_evt[g] = pif.evt;
         tlic_pin_detect u_det (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .pif(pif)
         );
      end
      for (g = 0; g < N_CHG; g++) begin : g_chg
         tlic_pin_if pif();
         assign pif.pin = i_chg_pin[g];
         assign pif.edge_sel = 1'b0;
         assign pif.any_edge = 1'b1;
         assign chg_evt[g] = pif.evt;
         tlic_pin_detect u_det (
            .i_clk(i_clk),
            .i_nrst(i_nrst),
            .pif(pif)
         );
      end
   endgenerate

   // flags of all five flag registers, the enables and priorities of their
   // partners, plus reset control and interrupt control, form the map
   assign src_evt = {i_periph_evt, |chg_evt, ext_evt};
   assign periph_mask = {{N_PERIPH{1'b1}}, {SRC_PERIPH_LO{1'b0}}};

   // set wins over a clear in the same cycle, so no event is lost
   always_comb begin
      next_flags = (flags & ~i_flag_clr) | src_evt;
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         flags <= '0;
      end else begin
         flags <= next_flags;
      end
   end

   // a source is armed once its flag and its own enable are both set
   assign armed = flags & i_source_enable;
   assign hi_busy = (state == ST_HIGH) || (state == ST_NEST);

   always_comb begin
      if (pmode) begin
         hi_cand = gen_high && |(armed & i_source_priority);
         lo_cand = gen_low && |(armed & ~i_source_priority) && !hi_busy;
      end else begin
         hi_cand = gen_high && |(armed & (~periph_mask | (periph_mask & {N_SRC{gen_low}})));
         lo_cand = 1'b0;
      end
   end

   // a return in progress wins; the request is taken on the following cycle
   assign take_high = hi_cand && !i_return_from_interrupt_instr;
   assign take_low = lo_cand && !hi_cand && !i_return_from_interrupt_instr;

   always_comb begin
      next_pmode = pmode;
      if (i_reset_control_wr) begin
         next_pmode = i_reset_control_wdata[PMODE_BIT];
      end
   end

   always_comb begin
      next_gen_high = gen_high;
      next_gen_low = gen_low;
      next_state = state;
      if (i_interrupt_control_wr) begin
         next_gen_high = i_interrupt_control_wdata[GEN_HIGH_BIT];
         next_gen_low = i_interrupt_control_wdata[GEN_LOW_BIT];
      end
      if (i_return_from_interrupt_instr) begin
         case (state)
            ST_NEST: begin
               next_state = ST_LOW;
               next_gen_high = 1'b1;
            end
            ST_HIGH: begin
               next_state = ST_NONE;
               next_gen_high = 1'b1;
            end
            ST_LOW: begin
               next_state = ST_NONE;
               next_gen_low = 1'b1;
            end
            default: begin
               next_state = state;
            end
         endcase
      end else if (take_high) begin
         next_gen_high = 1'b0;
         next_state = (state == ST_LOW) ? ST_NEST : ST_HIGH;
      end else if (take_low) begin
         next_gen_low = 1'b0;
         next_state = ST_LOW;
      end
   end

   always_comb begin
      next_vec_load = take_high || take_low;
      next_vec_addr = vec_addr;
      next_push_addr = push_addr;
      if (take_high) begin
         next_vec_addr = VEC_HIGH;
         next_push_addr = i_return_pc;
      end else if (take_low) begin
         next_vec_addr = VEC_LOW;
         next_push_addr = i_return_pc;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pmode <= RST_PMODE;
         gen_high <= RST_GEN;
         gen_low <= RST_GEN;
         state <= ST_NONE;
         vec_load <= 1'b0;
         vec_addr <= '0;
         push_addr <= '0;
      end else begin
         pmode <= next_pmode;
         gen_high <= next_gen_high;
         gen_low <= next_gen_low;
         state <= next_state;
         vec_load <= next_vec_load;
         vec_addr <= next_vec_addr;
         push_addr <= next_push_addr;
      end
   end

   always_comb begin
      o_interrupt_control = '0;
      o_interrupt_control[GEN_HIGH_BIT] = gen_high;
      o_interrupt_control[GEN_LOW_BIT] = gen_low;
   end

   assign o_flags = flags;
   assign o_priority_mode_enable = pmode;
   assign o_high_active = hi_busy;
   assign o_low_active = (state == ST_LOW) || (state == ST_NEST);
   assign o_vector_load = vec_load;
   assign o_vector_addr = vec_addr;
   assign o_push_addr = push_addr;
   // wake ignores the global enables, so polled sleep still ends
   assign o_wake = |armed;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_high_vector_addr: assert property (
      take_high |=> o_vector_load && o_vector_addr == VEC_HIGH && o_push_addr == $past(i_return_pc))
      else $error("high request did not load the high vector");
   a_low_vector_addr: assert property (
      take_low |=> o_vector_load && o_vector_addr == VEC_LOW)
      else $error("low request did not load the low vector");
   a_high_preempts_low: assert property (
      state == ST_LOW && hi_cand && !i_return_from_interrupt_instr |=> state == ST_NEST)
      else $error("high request failed to preempt a low routine");
   a_compat_one_level: assert property (
      !pmode && !$past(pmode) |-> !take_low ##1 (!o_vector_load || o_vector_addr == VEC_HIGH))
      else $error("compatibility mode used the low vector");
   a_enable_cleared: assert property (
      take_high |=> !gen_high && o_high_active)
      else $error("high global enable not cleared on entry");
   a_low_held_off: assert property (
      o_high_active && !i_return_from_interrupt_instr
      |=> !(o_vector_load && o_vector_addr == VEC_LOW))
      else $error("low request taken during a high routine");
   a_return_restores: assert property (
      state == ST_LOW && i_return_from_interrupt_instr |=> gen_low && state == ST_NONE)
      else $error("return did not restore the low global enable");
   a_flag_sticky: assert property (
      |src_evt |=> (flags & $past(src_evt)) == $past(src_evt))
      else $error("event did not set its flag");
   a_immediate_vector: assert property (
      pmode && gen_low && !hi_busy && !i_return_from_interrupt_instr
      && |(armed & ~i_source_priority) |=> o_vector_load)
      else $error("armed low source did not vector in one cycle");
   // low entry and the addresses that must hold between entries
   a_low_enable_cleared: assert property (
      take_low |=> !gen_low && o_low_active && !o_high_active)
      else $error("low global enable not cleared on entry");
   a_low_push_addr: assert property (
      take_low |=> o_push_addr == $past(i_return_pc))
      else $error("low entry pushed a wrong return address");
   a_vector_addr_hold: assert property (
      !take_high && !take_low |=> o_vector_addr == $past(o_vector_addr)
      && o_push_addr == $past(o_push_addr))
      else $error("vector or push address moved without an entry");

   // exits: a return closes one level and blocks entry for that cycle
   a_return_from_high: assert property (
      state == ST_HIGH && i_return_from_interrupt_instr |=> gen_high && state == ST_NONE)
      else $error("return did not close the high routine");
   a_return_from_nest: assert property (
      state == ST_NEST && i_return_from_interrupt_instr |=> gen_high && state == ST_LOW)
      else $error("return from a nested routine did not resume the low routine");
   a_return_no_entry: assert property (
      i_return_from_interrupt_instr |=> !o_vector_load)
      else $error("entry taken in the cycle of a return");

   // gating by the global enables in both modes, and routing by the priority bits
   a_compat_periph_gate: assert property (
      !pmode && !gen_low && !(|(armed & ~periph_mask)) |=> !o_vector_load)
      else $error("peripheral source entered with the peripheral enable clear");
   a_global_gate: assert property (
      !gen_high && !(pmode && gen_low) |=> !o_vector_load)
      else $error("entry taken with the admitting global enable clear");
   a_priority_route: assert property (
      pmode && !(|(armed & i_source_priority)) |=> !o_vector_load || o_vector_addr == VEC_LOW)
      else $error("high vector taken with no armed high-priority source");

   // mode bit, flag bookkeeping and state encoding
   a_pmode_write: assert property (
      i_reset_control_wr && i_reset_control_wdata[PMODE_BIT] |=> pmode)
      else $error("priority mode bit not taken from the write");
   a_pmode_hold: assert property (
      !i_reset_control_wr |=> pmode == $past(pmode))
      else $error("priority mode changed without a write");
   a_flag_cleared: assert property (
      |i_flag_clr |=> (flags & $past(i_flag_clr) & ~$past(src_evt)) == '0)
      else $error("flag clear did not take effect");
   a_flag_held: assert property (
      !(|i_flag_clr) |=> (flags & $past(flags)) == $past(flags))
      else $error("flag dropped without a clear");
   a_state_onehot: assert property (
      $onehot(state))
      else $error("routine state is not one-hot");

   // main scenarios
   c_nested_entry: cover property (state == ST_LOW ##1 state == ST_NEST);
   c_low_entry: cover property (pmode && take_low ##1 o_vector_load);
   c_compat_entry: cover property (!pmode && take_high);
   c_nested_return: cover property (state == ST_NEST && i_return_from_interrupt_instr);
   c_pin_entry: cover property (|src_evt[SRC_CHG-1:SRC_EXT_LO] ##2 o_vector_load);
endmodule
`default_nettype wire

// ---- test/tlic_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// stands in for the CPU: fetches sequentially, jumps on vector load
module tlic_cpu_model (
   input wire logic i_clk,
   input wire logic i_nrst,
   input wire logic i_vector_load,
   input wire logic [tlic_pkg::PC_W-1:0] i_vector_addr,
   input wire logic i_ret_go,
   output logic o_return,
   output logic [tlic_pkg::PC_W-1:0] o_pc
);
   import tlic_pkg::*;
   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_pc <= 21'h000100;
         o_return <= 1'b0;
      end else begin
         // return only when the bench asks, after it has cleared the flags
         o_return <= i_ret_go;
         o_pc <= i_vector_load ? i_vector_addr : o_pc + 21'h000001;
      end
   end
endmodule
`default_nettype wire

// ---- test/tb_two_level_interrupt_controller.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb_two_level_interrupt_controller;
   import tlic_pkg::*;
   localparam int NS = SRC_PERIPH_LO + 8;
   logic i_clk, i_nrst, rc_wr, ic_wr, ret_go, ret_pulse, pmode, hi_act, lo_act, vload, wake;
   logic [N_EXT-1:0] ext_pin, edge_sel;
   logic [N_CHG-1:0] chg_pin;
   logic [7:0] periph_evt, rc_wdata, ic_wdata, ic;
   logic [NS-1:0] src_en, src_pri, flag_clr, flags;
   logic [PC_W-1:0] ret_pc, vaddr, push;
   int errors = 0;
   int total_checks = 0;
   int lat;
   tlic_core #(.N_PERIPH(8)) i_tlic_core (.i_clk(i_clk), .i_nrst(i_nrst),
      .i_ext_pin(ext_pin), .i_external_edge_select(edge_sel), .i_chg_pin(chg_pin),
      .i_periph_evt(periph_evt), .i_source_enable(src_en), .i_source_priority(src_pri),
      .i_flag_clr(flag_clr), .i_reset_control_wr(rc_wr), .i_reset_control_wdata(rc_wdata),
      .i_interrupt_control_wr(ic_wr), .i_interrupt_control_wdata(ic_wdata),
      .i_return_from_interrupt_instr(ret_pulse), .i_return_pc(ret_pc), .o_flags(flags),
      .o_priority_mode_enable(pmode), .o_interrupt_control(ic), .o_high_active(hi_act),
      .o_low_active(lo_act), .o_vector_load(vload), .o_vector_addr(vaddr),
      .o_push_addr(push), .o_wake(wake));
   tlic_cpu_model i_tlic_cpu_model (.i_clk(i_clk), .i_nrst(i_nrst), .i_vector_load(vload),
      .i_vector_addr(vaddr), .i_ret_go(ret_go), .o_return(ret_pulse), .o_pc(ret_pc));
   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end
   task automatic test_done;
      if (errors == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   // kinds: 0 reset control, 1 interrupt control, 2 peripheral event, 3 flag clear, 4 return
   task automatic pulse(input int kind, input logic [15:0] v);
      @(posedge i_clk);
      case (kind)
         0: begin rc_wr <= 1'b1; rc_wdata <= v[7:0]; end
         1: begin ic_wr <= 1'b1; ic_wdata <= v[7:0]; end
         2: periph_evt <= v[7:0];
         3: flag_clr <= v[NS-1:0];
         default: ret_go <= 1'b1;
      endcase
      @(posedge i_clk);
      {rc_wr, ic_wr, ret_go} <= 3'h0;
      periph_evt <= 8'h00;
      flag_clr <= '0;
      #1;
   endtask
   task automatic quiet(input int n);
      repeat (n) begin
         cyc(1);
         chk("vector_load idle", 32'h0, {31'h0, vload});
      end
   endtask
   // push address is the fetch address presented at the edge that took the request
   task automatic entry(input logic [PC_W-1:0] vec);
      logic [PC_W-1:0] prev;
      lat = 0;
      prev = ret_pc;
      while (vload !== 1'b1 && lat < 12) begin
         prev = ret_pc;
         cyc(1);
         lat++;
      end
      chk("vector_load", 32'h1, {31'h0, vload});
      chk("vector_addr", {11'h0, vec}, {11'h0, vaddr});
      chk("push_addr", {11'h0, prev}, {11'h0, push});
   endtask
   initial begin
      #(50 * 4000);
      errors++;
      test_done();
   end
   initial begin
      i_nrst = 1'b0;
      {rc_wr, ic_wr, ret_go} = 3'h0;
      {rc_wdata, ic_wdata, periph_evt} = 24'h0;
      {ext_pin, chg_pin} = 8'h00;
      edge_sel = 4'h5;
      {src_en, src_pri, flag_clr} = '0;
      repeat (6) @(posedge i_clk);
      i_nrst <= 1'b1;
      cyc(1);
      chk("flags", 32'h0, {19'h0, flags});
      chk("pmode", 32'h0, {31'h0, pmode});
      chk("ctrl", 32'h0, {24'h0, ic});
      chk("active", 32'h0, {30'h0, hi_act, lo_act});
      chk("wake", 32'h0, {31'h0, wake});
      pulse(2, 16'h1);
      chk("flags", 32'h20, {19'h0, flags});
      chk("wake", 32'h0, {31'h0, wake});
      @(posedge i_clk);
      src_en[5] <= 1'b1;
      quiet(3);
      chk("wake", 32'h1, {31'h0, wake});
      pulse(3, 16'h20);
      chk("flags", 32'h0, {19'h0, flags});
      // pins 0 and 2 take rising edges, 1 and 3 falling
      @(posedge i_clk);
      ext_pin <= 4'hf;
      chg_pin <= 4'h4;
      cyc(5);
      chk("flags", 32'h15, {19'h0, flags});
      pulse(3, 16'h1f);
      @(posedge i_clk);
      ext_pin <= 4'h0;
      cyc(5);
      chk("flags", 32'h0a, {19'h0, flags});
      pulse(3, 16'h1f);
      @(posedge i_clk);
      src_en <= '1;
      pulse(1, 16'h40);
      pulse(2, 16'h1);
      quiet(3);
      pulse(3, 16'h20);
      pulse(1, 16'h80);
      pulse(2, 16'h1);
      quiet(3);
      pulse(3, 16'h20);
      @(posedge i_clk);
      ext_pin[0] <= 1'b1;
      #1;
      entry(VEC_HIGH);
      chk("latency", 32'h1, {31'h0, lat >= 3 && lat <= 4});
      chk("ctrl", 32'h0, {24'h0, ic});
      pulse(3, 16'h1);
      pulse(4, 16'h0);
      cyc(1);
      chk("ctrl", 32'h80, {24'h0, ic});
      pulse(1, 16'hc0);
      pulse(2, 16'h1);
      entry(VEC_HIGH);
      chk("ctrl", 32'h40, {24'h0, ic});
      pulse(3, 16'h20);
      pulse(4, 16'h0);
      cyc(1);
      chk("ctrl", 32'hc0, {24'h0, ic});
      pulse(0, 16'h80);
      chk("pmode", 32'h1, {31'h0, pmode});
      @(posedge i_clk);
      src_pri <= 13'h0040;
      pulse(2, 16'h1);
      entry(VEC_LOW);
      chk("ctrl", 32'h80, {24'h0, ic});
      chk("active", 32'h1, {30'h0, hi_act, lo_act});
      pulse(2, 16'h2);
      entry(VEC_HIGH);
      chk("ctrl", 32'h0, {24'h0, ic});
      chk("active", 32'h3, {30'h0, hi_act, lo_act});
      pulse(1, 16'h40);
      pulse(2, 16'h4);
      quiet(4);
      pulse(3, 16'he0);
      pulse(4, 16'h0);
      cyc(1);
      chk("active", 32'h1, {30'h0, hi_act, lo_act});
      chk("ctrl", 32'hc0, {24'h0, ic});
      pulse(1, 16'h80);
      pulse(4, 16'h0);
      cyc(1);
      chk("active", 32'h0, {30'h0, hi_act, lo_act});
      chk("ctrl", 32'hc0, {24'h0, ic});
      test_done();
   end
endmodule
`default_nettype wire
